// ### tb_tlsg_guard.sv
// self-checking bench for the travel limit and speed guard
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("mismatch %s exp %h got %h", nm, e, g); \
    end \
end

module tb_tlsg_guard;
    import tlsg_pkg::*;
    logic i_ref_clk, i_nrst, i_prog_start, i_reg_limit_wr, i_reg_move_start;
    logic i_reg_trigger, i_pos_lim_wr, i_neg_lim_wr, i_check_on, i_check_off;
    logic i_err_clr, i_speed_wr, go, home, i_move_active, i_move_dir;
    logic i_homing, o_reg_active, o_reg_bounded, o_reg_reached;
    logic o_reg_triggered, o_check_en, o_max_decel_stop, o_err_stb;
    tlsg_pos_t i_reg_limit_val, i_pos_lim_val, i_neg_lim_val, i_abs_pos;
    tlsg_pos_t i_speed_val, tgt, p, o_reg_limit, o_reg_end_pos;
    tlsg_pos_t o_pos_lim, o_neg_lim;
    tlsg_speed_t i_max_speed, o_target_speed;
    tlsg_err_t o_err_code;
    int mismatches = 0, cmp_count = 0, nstb = 0, nrch = 0, ntrg = 0;

    tlsg_guard dut (.*);
    tlsg_traj_model model (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
        .i_go(go), .i_home(home), .i_halt(o_max_decel_stop),
        .i_target(tgt), .o_move_active(i_move_active),
        .o_move_dir(i_move_dir), .o_homing(i_homing), .o_abs_pos(i_abs_pos));

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    always #12.5 i_ref_clk = ~i_ref_clk;
    always @(negedge i_ref_clk) begin
        nstb += o_err_stb;
        nrch += o_reg_reached;
        ntrg += o_reg_triggered;
    end
    task tick; @(posedge i_ref_clk); #1; endtask
    task automatic pulse(ref logic s); s = 1'b1; tick(); s = 1'b0; endtask
    task start_move(input tlsg_pos_t t, input logic h);
        {tgt, home, go, nstb, nrch, ntrg} = {t, h, 1'b1, 96'h0};
        tick();
        go = 1'b0;
    endtask
    task wait_move;
        for (int n = 0; n < 400 && i_move_active; n++) tick();
        tick();
    endtask
    task run_to(input tlsg_pos_t t, input logic h);
        start_move(t, h);
        wait_move();
    endtask
    task end_sim;
        $display("compared %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task t_limits;
        {i_pos_lim_val, i_neg_lim_val} = {32'sh14, -32'sh14};
        {i_pos_lim_wr, i_neg_lim_wr} = 2'h3;
        tick();
        {i_pos_lim_wr, i_neg_lim_wr} = 2'h0;
        `CHK("pos_lim", 32'sh14, o_pos_lim)
        `CHK("neg_lim", -32'sh14, o_neg_lim)
        pulse(i_check_on);
        `CHK("check_on", 1'b1, o_check_en)
        pulse(i_check_off);
        `CHK("check_off", 1'b0, o_check_en)
        pulse(i_check_on);
        $display("done limits");
    endtask
    task t_viol;
        run_to(32'sh14, 1'b0);
        `CHK("err_equal", 8'h00, o_err_code)
        run_to(32'sh1e, 1'b0);
        `CHK("err_pos", 8'h82, o_err_code)
        `CHK("stb_pos", 1, nstb)
        `CHK("stopped", 1'b1, i_abs_pos < 32'sh1e)
        `CHK("halt_off", 1'b0, o_max_decel_stop)
        pulse(i_err_clr);
        run_to(-32'sh1e, 1'b0);
        `CHK("err_neg", 8'h83, o_err_code)
        `CHK("stb_neg", 1, nstb)
        pulse(i_err_clr);
        run_to(-32'sh28, 1'b1);
        `CHK("err_home", 8'h00, o_err_code)
        pulse(i_check_off);
        run_to(-32'sh32, 1'b0);
        `CHK("err_off", 8'h00, o_err_code)
        pulse(i_check_on);
        pulse(i_prog_start);
        `CHK("run_off", 1'b0, o_check_en)
        `CHK("run_pos", 32'sh7ffff82f, o_pos_lim)
        $display("done violations");
    endtask
    task t_speed;
        tlsg_pos_t req[5];
        tlsg_speed_t want[5];
        req = '{-32'sh5, 32'sh4e21, 32'sh7, 32'sh3e8, 32'sh0};
        want = '{32'h0, 32'h4e20, 32'hf, 32'h3e8, 32'h0};
        i_speed_wr = 1'b1;
        for (int k = 0; k < 5; k++) begin
            i_speed_val = req[k];
            tick();
            `CHK("speed", want[k], o_target_speed)
        end
        i_speed_wr = 1'b0;
        start_move(-32'sh3c, 1'b0);
        i_speed_val = 32'sh1f4;
        pulse(i_speed_wr);
        `CHK("speed_move", 32'h1f4, o_target_speed)
        `CHK("moving", 1'b1, i_move_active)
        wait_move();
        $display("done speed");
    endtask
    task t_reg;
        i_reg_limit_val = -32'sh7;
        pulse(i_reg_limit_wr);
        `CHK("reg_neg", 32'sh0, o_reg_limit)
        start_move(32'sh0, 1'b0);
        pulse(i_reg_move_start);
        `CHK("endless", 1'b0, o_reg_bounded)
        repeat (30) tick();
        `CHK("awaiting", 1'b1, o_reg_active)
        pulse(i_reg_trigger);
        tick();
        `CHK("trig_end", 1'b0, o_reg_active)
        `CHK("trig_cnt", 1, ntrg)
        wait_move();
        i_reg_limit_val = 32'sha;
        pulse(i_reg_limit_wr);
        start_move(32'sh64, 1'b0);
        p = i_abs_pos;
        pulse(i_reg_move_start);
        `CHK("end_pos", p + 32'sha, o_reg_end_pos)
        `CHK("bounded", 1'b1, o_reg_bounded)
        for (int n = 0; n < 40 && o_reg_active; n++) tick();
        `CHK("reach_pls", 1'b1, o_reg_reached)
        tick();
        `CHK("reached", 1, nrch)
        wait_move();
        $display("done registration");
    endtask

    initial begin
        {i_ref_clk, i_nrst, i_prog_start, i_reg_limit_wr} = 4'h0;
        {i_reg_move_start, i_reg_trigger, i_pos_lim_wr} = 3'h0;
        {i_neg_lim_wr, i_check_on, i_check_off, i_err_clr} = 4'h0;
        {i_speed_wr, go, home, i_max_speed} = {3'h0, 32'h4e20};
        {i_reg_limit_val, i_pos_lim_val, i_neg_lim_val} = 96'h0;
        {i_speed_val, tgt} = 64'h0;
        repeat (6) @(posedge i_ref_clk);
        #1;
        `CHK("def_pos", 32'sh7ffff82f, o_pos_lim)
        `CHK("def_neg", 32'sh800007d1, o_neg_lim)
        `CHK("def_chk", 1'b0, o_check_en)
        i_nrst = 1'b1;
        tick();
        `CHK("speed_init", 32'h1388, o_target_speed)
        t_limits();
        t_viol();
        t_speed();
        t_reg();
        end_sim();
    end

    initial begin
        #125000;
        mismatches++;
        end_sim();
    end
endmodule // tb_tlsg_guard

// ### tlsg_cfg.svh
// constants for the travel limit and speed guard
`ifndef TLSG_CFG_SVH
`define TLSG_CFG_SVH

// soft limit defaults, encoder counts either side of zero
`define TLSG_POS_LIM_DEF   32'h7ffff82f
`define TLSG_NEG_LIM_DEF   32'h800007d1

// error codes posted on a soft limit violation (130 and 131)
`define TLSG_ERR_NONE      8'h00
`define TLSG_ERR_POS       8'h82
`define TLSG_ERR_NEG       8'h83

// speed word: one lsb is this many nano-revolutions per second
`define TLSG_SPEED_LSB_NRPS  10000
// lowest programmable nonzero speed, nano-revolutions per second
`define TLSG_SPEED_MIN_NRPS  150000
// least speed in lsbs, rounded up to a whole lsb
`define TLSG_SPEED_MIN_CNT \
    ((`TLSG_SPEED_MIN_NRPS + `TLSG_SPEED_LSB_NRPS - 1) / \
     `TLSG_SPEED_LSB_NRPS)
// power-up speed is max speed shifted right by this (25 percent)
`define TLSG_SPEED_INIT_SHR  2

`endif

// ### tlsg_guard.sv
// travel limit and speed guard: soft limits, registration, speed clamp
`timescale 1ns/10ps
`include "tlsg_cfg.svh"

module tlsg_guard (
    input  wire logic                i_ref_clk,       // 40 MHz clock
    input  wire logic                i_nrst,          // sync reset, low
    input  wire logic                i_prog_start,    // program run, pulse
    // registration move
    input  wire logic                i_reg_limit_wr,  // distance write
    input  wire tlsg_pkg::tlsg_pos_t i_reg_limit_val, // distance, counts
    input  wire logic                i_reg_move_start,// registration start
    input  wire logic                i_reg_trigger,   // registration trigger
    // soft limits
    input  wire logic                i_pos_lim_wr,    // positive limit write
    input  wire tlsg_pkg::tlsg_pos_t i_pos_lim_val,   // absolute position
    input  wire logic                i_neg_lim_wr,    // negative limit write
    input  wire tlsg_pkg::tlsg_pos_t i_neg_lim_val,   // absolute position
    input  wire logic                i_check_on,      // enable command
    input  wire logic                i_check_off,     // disable command
    input  wire logic                i_err_clr,       // clear error code
    // motion state from the trajectory generator
    input  wire logic                i_move_active,   // motion in progress
    input  wire logic                i_move_dir,      // 1 = positive
    input  wire logic                i_homing,        // homing move
    input  wire tlsg_pkg::tlsg_pos_t i_abs_pos,       // commanded position
    // speed
    input  wire logic                i_speed_wr,      // speed write
    input  wire tlsg_pkg::tlsg_pos_t i_speed_val,     // signed request
    input  wire tlsg_pkg::tlsg_speed_t i_max_speed,   // configured maximum
    // outputs
    output tlsg_pkg::tlsg_pos_t      o_reg_limit,     // stored distance
    output logic                     o_reg_active,    // awaiting trigger
    output logic                     o_reg_bounded,   // distance applies
    output tlsg_pkg::tlsg_pos_t      o_reg_end_pos,   // bounded end point
    output logic                     o_reg_reached,   // end reached, pulse
    output logic                     o_reg_triggered, // trigger, pulse
    output tlsg_pkg::tlsg_pos_t      o_pos_lim,       // positive limit
    output tlsg_pkg::tlsg_pos_t      o_neg_lim,       // negative limit
    output logic                     o_check_en,      // limits checked
    output logic                     o_max_decel_stop,// stop at max accel
    output tlsg_pkg::tlsg_err_t      o_err_code,      // 0, 130 or 131
    output logic                     o_err_stb,       // new error, pulse
    output tlsg_pkg::tlsg_speed_t    o_target_speed   // applied speed
);
    import tlsg_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        tlsg_guard_state_t state;
        tlsg_pos_t         reg_limit;
        tlsg_pos_t         pos_lim;
        tlsg_pos_t         neg_lim;
        logic              check_en;
        logic              halt;
        tlsg_err_t         err_code;
        logic              err_stb;
        tlsg_speed_t       speed;
        logic              speed_init;
    } tlsg_guard_st_t;

    tlsg_guard_st_t st_ff;
    tlsg_guard_st_t nxt_st;

    localparam tlsg_speed_t SPEED_MIN =
        tlsg_speed_t'(`TLSG_SPEED_MIN_CNT);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // negative requests fold to zero
    function automatic tlsg_pos_t floor_zero(input tlsg_pos_t v);
        floor_zero = (v < 0) ? 32'h0 : v;
    endfunction

    // positive speed request clamped between the least step and the maximum; zero or negative gives zero
    function automatic tlsg_speed_t clamp_speed(input tlsg_pos_t v,
                                                input tlsg_speed_t mx);
        tlsg_speed_t u;
        u = tlsg_speed_t'(floor_zero(v));
        if (u > mx) begin
            u = mx;
        end else if ((u != 32'h0) && (u < SPEED_MIN)) begin
            u = SPEED_MIN;
        end
        clamp_speed = u;
    endfunction

    // ------------------------------------------------------------
    // soft limit compare
    // ------------------------------------------------------------
    logic over_pos;
    logic over_neg;

    // each limit only looks in its own direction of travel
    assign over_pos = i_move_dir && (i_abs_pos > st_ff.pos_lim);
    assign over_neg = !i_move_dir && (i_abs_pos < st_ff.neg_lim);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st         = st_ff;
        nxt_st.err_stb = 1'b0;

        // registration distance; the program must load it first
        if (i_reg_limit_wr) begin
            nxt_st.reg_limit = floor_zero(i_reg_limit_val);
        end

        // soft limits stored as absolute positions
        if (i_pos_lim_wr) begin
            nxt_st.pos_lim = i_pos_lim_val;
        end
        if (i_neg_lim_wr) begin
            nxt_st.neg_lim = i_neg_lim_val;
        end

        // both limits switch together; off wins a same-cycle tie
        if (i_check_on) begin
            nxt_st.check_en = 1'b1;
        end
        if (i_check_off) begin
            nxt_st.check_en = 1'b0;
        end

        // speed: a write lands at once, even mid-move
        if (i_speed_wr) begin
            nxt_st.speed      = clamp_speed(i_speed_val, i_max_speed);
            nxt_st.speed_init = 1'b0;
        end else if (st_ff.speed_init) begin
            // max speed is sampled the cycle after reset release
            nxt_st.speed      = i_max_speed >> `TLSG_SPEED_INIT_SHR;
            nxt_st.speed_init = 1'b0;
        end

        if (i_err_clr) begin
            nxt_st.err_code = `TLSG_ERR_NONE;
        end

        // motion supervision
        unique case (st_ff.state)
            GUARD_IDLE: begin
                if (i_move_active && !i_homing) begin
                    nxt_st.state = GUARD_WATCH;
                end
            end
            GUARD_WATCH: begin
                if (!i_move_active || i_homing) begin
                    nxt_st.state = GUARD_IDLE;
                end else if (st_ff.check_en && (over_pos || over_neg)) begin
                    nxt_st.state    = GUARD_HALT;
                    nxt_st.halt     = 1'b1;
                    nxt_st.err_stb  = 1'b1;
                    // a new error wins over a clear in the same cycle
                    nxt_st.err_code = over_pos ? `TLSG_ERR_POS
                                               : `TLSG_ERR_NEG;
                end
            end
            GUARD_HALT: begin
                // hold the fast stop until the generator reports rest
                if (!i_move_active) begin
                    nxt_st.state = GUARD_IDLE;
                    nxt_st.halt  = 1'b0;
                end
            end
        endcase

        // a new program starts from the power-up limit setup
        if (i_prog_start) begin
            nxt_st.check_en = 1'b0;
            nxt_st.pos_lim  = `TLSG_POS_LIM_DEF;
            nxt_st.neg_lim  = `TLSG_NEG_LIM_DEF;
            nxt_st.state    = GUARD_IDLE;
            nxt_st.halt     = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            st_ff.state      <= GUARD_IDLE;
            st_ff.reg_limit  <= 32'h0;
            st_ff.pos_lim    <= `TLSG_POS_LIM_DEF;
            st_ff.neg_lim    <= `TLSG_NEG_LIM_DEF;
            st_ff.check_en   <= 1'b0;
            st_ff.halt       <= 1'b0;
            st_ff.err_code   <= `TLSG_ERR_NONE;
            st_ff.err_stb    <= 1'b0;
            st_ff.speed      <= 32'h0;
            st_ff.speed_init <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // registration tracker
    // ------------------------------------------------------------
    tlsg_reg_track u_reg_track (
        .i_ref_clk   (i_ref_clk),
        .i_nrst      (i_nrst),
        .i_abort     (i_prog_start),
        .i_start     (i_reg_move_start),
        .i_trigger   (i_reg_trigger),
        .i_dir       (i_move_dir),
        .i_abs_pos   (i_abs_pos),
        .i_limit     (st_ff.reg_limit),
        .o_active    (o_reg_active),
        .o_bounded   (o_reg_bounded),
        .o_end_pos   (o_reg_end_pos),
        .o_reached   (o_reg_reached),
        .o_triggered (o_reg_triggered)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_reg_limit      = st_ff.reg_limit;
    assign o_pos_lim        = st_ff.pos_lim;
    assign o_neg_lim        = st_ff.neg_lim;
    assign o_check_en       = st_ff.check_en;
    assign o_max_decel_stop = st_ff.halt;
    assign o_err_code       = st_ff.err_code;
    assign o_err_stb        = st_ff.err_stb;
    assign o_target_speed   = st_ff.speed;

endmodule // tlsg_guard

// ### tlsg_guard_sva.sv
// assertion checker for the travel limit and speed guard
`timescale 1ns/10ps

module tlsg_guard_sva (
    input wire logic                  i_ref_clk,        // clock
    input wire logic                  i_nrst,           // sync reset, low
    input wire logic                  i_prog_start,     // program start
    input wire logic                  i_reg_limit_wr,   // distance write
    input wire tlsg_pkg::tlsg_pos_t   i_reg_limit_val,  // distance
    input wire logic                  i_reg_move_start, // registration go
    input wire logic                  i_reg_trigger,    // trigger
    input wire logic                  i_check_on,       // enable command
    input wire logic                  i_check_off,      // disable command
    input wire logic                  i_move_dir,       // 1 = positive
    input wire logic                  i_speed_wr,       // speed write
    input wire tlsg_pkg::tlsg_pos_t   i_speed_val,      // speed request
    input wire tlsg_pkg::tlsg_speed_t i_max_speed,      // maximum speed
    input wire tlsg_pkg::tlsg_pos_t   o_reg_limit,      // stored distance
    input wire logic                  o_reg_active,     // awaiting trigger
    input wire logic                  o_reg_bounded,    // distance applies
    input wire logic                  o_check_en,       // checking on
    input wire logic                  o_max_decel_stop, // halt
    input wire tlsg_pkg::tlsg_err_t   o_err_code,       // error code
    input wire logic                  o_err_stb,        // new error
    input wire tlsg_pkg::tlsg_speed_t o_target_speed    // applied speed
);
    import tlsg_pkg::*;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    // --------------------------------------------------------------
    // properties
    // --------------------------------------------------------------
    AST_REG_NEG: assert property (
        i_reg_limit_wr && i_reg_limit_val[31] |=> o_reg_limit == 32'sh0)
        else $error("negative distance not stored as zero");
    AST_REG_START: assert property (
        i_reg_move_start && !o_reg_active && !i_reg_trigger && !i_prog_start
        |=> o_reg_active && (o_reg_bounded == ($past(o_reg_limit) != 0)))
        else $error("registration start state wrong");
    AST_CHECK_OFF: assert property (
        i_check_off || i_prog_start |=> !o_check_en)
        else $error("checking still on");
    AST_CHECK_ON: assert property (
        i_check_on && !i_check_off && !i_prog_start |=> o_check_en)
        else $error("checking not on");
    AST_SPEED_HI: assert property (
        i_speed_wr && !i_speed_val[31] && i_speed_val > i_max_speed
        |=> o_target_speed == $past(i_max_speed))
        else $error("speed not clamped to maximum");
    AST_SPEED_NEG: assert property (
        i_speed_wr && (i_speed_val[31] || i_speed_val == 0)
        |=> o_target_speed == 32'h0)
        else $error("speed not zero");
    AST_SPEED_MIN: assert property (
        i_speed_wr && i_speed_val > 32'sh0 && i_speed_val < 32'shf
        && i_max_speed >= 32'hf |=> o_target_speed == 32'hf)
        else $error("speed below least step");
    AST_STOP_ERR: assert property (
        $rose(o_max_decel_stop)
        |-> o_err_stb && o_err_code inside {8'h82, 8'h83})
        else $error("halt without error code");
    AST_DIR: assert property (
        o_err_stb |-> (o_err_code == 8'h82) == $past(i_move_dir))
        else $error("error code does not match direction");
    AST_GATE: assert property (
        !o_check_en |=> !o_err_stb)
        else $error("error while checking off");
endmodule // tlsg_guard_sva

bind tlsg_guard tlsg_guard_sva u_sva (.*);

// ### tlsg_pkg.sv
// types shared by the travel limit and speed guard
package tlsg_pkg;

    typedef logic signed [31:0] tlsg_pos_t;
    typedef logic        [31:0] tlsg_speed_t;
    typedef logic        [7:0]  tlsg_err_t;

    typedef enum logic [1:0] {
        REG_IDLE,
        REG_BOUNDED,
        REG_ENDLESS
    } tlsg_reg_state_t;

    typedef enum logic [1:0] {
        GUARD_IDLE,
        GUARD_WATCH,
        GUARD_HALT
    } tlsg_guard_state_t;

endpackage

// ### tlsg_reg_track.sv
// registration move tracker: bounds travel while awaiting a trigger
`timescale 1ns/10ps
`include "tlsg_cfg.svh"

module tlsg_reg_track (
    input  wire logic              i_ref_clk,    // system clock
    input  wire logic              i_nrst,       // sync reset, low
    input  wire logic              i_abort,      // program start pulse
    input  wire logic              i_start,      // registration move start
    input  wire logic              i_trigger,    // registration trigger
    input  wire logic              i_dir,        // 1 = positive direction
    input  wire tlsg_pkg::tlsg_pos_t i_abs_pos,  // commanded position
    input  wire tlsg_pkg::tlsg_pos_t i_limit,    // travel distance, >= 0
    output logic                   o_active,     // move awaiting trigger
    output logic                   o_bounded,    // distance limit applies
    output tlsg_pkg::tlsg_pos_t    o_end_pos,    // position to stop at
    output logic                   o_reached,    // end reached, pulse
    output logic                   o_triggered   // trigger taken, pulse
);
    import tlsg_pkg::*;

    typedef struct packed {
        tlsg_reg_state_t state;
        logic            dir;
        tlsg_pos_t       end_pos;
        logic            reached;
        logic            triggered;
        logic            active;
        logic            bounded;
    } tlsg_reg_st_t;

    tlsg_reg_st_t st_ff;
    tlsg_reg_st_t nxt_st;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st           = st_ff;
        nxt_st.reached   = 1'b0;
        nxt_st.triggered = 1'b0;
        unique case (st_ff.state)
            REG_IDLE: begin
                if (i_start && !i_abort) begin
                    nxt_st.dir = i_dir;
                    // end point wraps at the 32-bit position boundary
                    nxt_st.end_pos = i_dir ? i_abs_pos + i_limit
                                           : i_abs_pos - i_limit;
                    nxt_st.state = (i_limit == 32'h0) ? REG_ENDLESS
                                                      : REG_BOUNDED;
                end
            end
            REG_BOUNDED: begin
                if (i_trigger) begin
                    nxt_st.triggered = 1'b1;
                    nxt_st.state     = REG_IDLE;
                end else if (st_ff.dir ? (i_abs_pos >= st_ff.end_pos)
                                       : (i_abs_pos <= st_ff.end_pos)) begin
                    // no trigger: ends as an incremental move
                    nxt_st.reached = 1'b1;
                    nxt_st.state   = REG_IDLE;
                end
            end
            REG_ENDLESS: begin
                // no distance check: runs until a trigger
                if (i_trigger) begin
                    nxt_st.triggered = 1'b1;
                    nxt_st.state     = REG_IDLE;
                end
            end
        endcase
        if (i_abort) begin
            nxt_st.state = REG_IDLE;
        end
        // decoded ahead of the register so the outputs leave a flop
        nxt_st.active  = (nxt_st.state != REG_IDLE);
        nxt_st.bounded = (nxt_st.state == REG_BOUNDED);
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            st_ff <= '{state: REG_IDLE, dir: 1'b0, end_pos: 32'h0,
                       reached: 1'b0, triggered: 1'b0,
                       active: 1'b0, bounded: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_active    = st_ff.active;
    assign o_bounded   = st_ff.bounded;
    assign o_end_pos   = st_ff.end_pos;
    assign o_reached   = st_ff.reached;
    assign o_triggered = st_ff.triggered;

endmodule // tlsg_reg_track

// ### tlsg_traj_model.sv
// trajectory generator model: one count a cycle, obeys the halt
`timescale 1ns/10ps

module tlsg_traj_model (
    input  wire logic                i_ref_clk,     // system clock
    input  wire logic                i_nrst,        // sync reset, low
    input  wire logic                i_go,          // start a move
    input  wire logic                i_home,        // homing move
    input  wire logic                i_halt,        // max accel stop
    input  wire tlsg_pkg::tlsg_pos_t i_target,      // end position
    output logic                     o_move_active, // in motion
    output logic                     o_move_dir,    // 1 = positive
    output logic                     o_homing,      // homing
    output tlsg_pkg::tlsg_pos_t      o_abs_pos      // commanded position
);
    import tlsg_pkg::*;
    tlsg_pos_t tgt_ff;
    logic      brake_ff;

    // --------------------------------------------------------------
    // motion
    // --------------------------------------------------------------
    // a halt lets one more count pass, a short stop at full accel
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_move_active <= 1'b0;
            o_move_dir    <= 1'b1;
            o_homing      <= 1'b0;
            o_abs_pos     <= 32'sh0;
            tgt_ff        <= 32'sh0;
            brake_ff      <= 1'b0;
        end else if (i_go && !o_move_active) begin
            o_move_active <= 1'b1;
            o_move_dir    <= (i_target >= o_abs_pos);
            o_homing      <= i_home;
            tgt_ff        <= i_target;
            brake_ff      <= 1'b0;
        end else if (o_move_active) begin
            if (o_abs_pos == tgt_ff || brake_ff) begin
                o_move_active <= 1'b0;
                o_homing      <= 1'b0;
            end else begin
                o_abs_pos <= o_move_dir ? o_abs_pos + 32'sh1
                                        : o_abs_pos - 32'sh1;
            end
            if (i_halt) begin
                brake_ff <= 1'b1;
            end
        end
    end
endmodule // tlsg_traj_model
